//--- design/clock_source_control.v
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Function
// - Main pin mode: 00/10 port, 01 crystal, 11 external.
// - Sub pin mode: 00/10 port, 01 crystal, 11 external.
// - Sub drive mode: low-power, normal, ultra-low; 11 forbidden.
// - Main frequency range bit: 0 up to 10MHz, 1 above.
// - Main halt bit stops crystal or invalidates external clock.
// - Sub halt bit stops crystal or invalidates external clock.
// - Internal fast oscillator halt bit stops it.
// - Supply gating keeps only RTC and timer in low power.
// - CPU clock select: 0 main clock, 1 subsystem clock.
// - Main source select: 0 internal fast, 1 external.
`include "clock_source_control_regs.vh"

module clock_source_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire stop_mode,
  input wire halt_mode,
  input wire main_clock_stable,
  input wire sub_clock_stable,
  input wire fast_osc_stable,
  output reg main_pin_port_mode,
  output reg main_osc_run,
  output reg main_ext_clock_valid,
  output reg main_freq_range,
  output reg sub_pin_port_mode,
  output reg sub_osc_run,
  output reg sub_ext_clock_valid,
  output reg [1:0] sub_drive_mode,
  output reg fast_osc_run,
  output reg sub_clock_periph_en,
  output reg sub_clock_rtc_timer_en,
  output reg interval_timer_clock_sel,
  output reg cpu_clock_from_sub,
  output reg main_clock_from_ext
);

  reg [7:0] pin_mode_reg;
  reg [7:0] run_ctrl_reg;
  reg [7:0] supply_reg;
  reg [7:0] sys_select_reg;
  reg cpu_status_reg;
  reg main_status_reg;
  reg [2:0] stable_meta_reg;
  reg [2:0] stable_sync_reg;
  reg [7:0] pin_mode_next;
  reg [7:0] read_data;
  reg addr_hit;
  wire access_phase;
  wire write_now;
  wire main_stable_s;
  wire sub_stable_s;
  wire fast_stable_s;
  wire [1:0] main_mode;
  wire [1:0] sub_mode;
  wire main_source_stable;
  wire low_power;
  wire sub_running;

  // Returns the mapped flag for a word offset.
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `CSC_PIN_MODE_OFFSET) || (addr == `CSC_RUN_CTRL_OFFSET) ||
               (addr == `CSC_SUPPLY_OFFSET) || (addr == `CSC_SYS_SELECT_OFFSET);
    end
  endfunction

  assign access_phase = psel && penable && !pready;
  assign write_now = psel && penable && pready && pwrite && !pslverr;

  // Oscillator ready levels come from analog cells outside this clock domain.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_meta_reg <= 3'h0;
      stable_sync_reg <= 3'h0;
    end else begin
      stable_meta_reg <= {fast_osc_stable, sub_clock_stable, main_clock_stable};
      stable_sync_reg <= stable_meta_reg;
    end
  end

  assign main_stable_s = stable_sync_reg[0];
  assign sub_stable_s = stable_sync_reg[1];
  assign fast_stable_s = stable_sync_reg[2];

  assign main_mode = {pin_mode_reg[`CSC_MAIN_EXT_CLOCK_SEL_BIT], pin_mode_reg[`CSC_MAIN_OSC_PIN_SEL_BIT]};
  assign sub_mode = {pin_mode_reg[`CSC_SUB_EXT_CLOCK_SEL_BIT], pin_mode_reg[`CSC_SUB_OSC_PIN_SEL_BIT]};

  // A write of the forbidden drive code leaves the drive field unchanged.
  always @* begin
    pin_mode_next = pwdata[7:0] & `CSC_PIN_MODE_MASK;
    if (pwdata[`CSC_SUB_DRIVE_MODE_HI_BIT:`CSC_SUB_DRIVE_MODE_LO_BIT] == `CSC_DRIVE_MODE_PROHIBITED) begin
      pin_mode_next[`CSC_SUB_DRIVE_MODE_HI_BIT:`CSC_SUB_DRIVE_MODE_LO_BIT] =
        pin_mode_reg[`CSC_SUB_DRIVE_MODE_HI_BIT:`CSC_SUB_DRIVE_MODE_LO_BIT];
    end
  end

  always @* begin
    addr_hit = mapped(paddr);
    read_data = 8'h00;
    case (paddr)
      `CSC_PIN_MODE_OFFSET: begin
        read_data = pin_mode_reg;
      end
      `CSC_RUN_CTRL_OFFSET: begin
        read_data = run_ctrl_reg;
      end
      `CSC_SUPPLY_OFFSET: begin
        read_data = supply_reg;
      end
      `CSC_SYS_SELECT_OFFSET: begin
        read_data = sys_select_reg;
        read_data[`CSC_CPU_CLOCK_STATUS_BIT] = cpu_status_reg;
        read_data[`CSC_MAIN_CLOCK_STATUS_BIT] = main_status_reg;
      end
      default: begin
        read_data = 8'h00;
      end
    endcase
  end

  // APB slave with one wait state so that every answer comes from a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access_phase;
      if (access_phase) begin
        pslverr <= !addr_hit;
        prdata <= (pwrite || !addr_hit) ? 32'h00000000 : {24'h000000, read_data};
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode_reg <= `CSC_PIN_MODE_RESET;
      run_ctrl_reg <= `CSC_RUN_CTRL_RESET;
      supply_reg <= `CSC_SUPPLY_RESET;
      sys_select_reg <= `CSC_SYS_SELECT_RESET;
    end else if (write_now) begin
      case (paddr)
        `CSC_PIN_MODE_OFFSET: begin
          pin_mode_reg <= pin_mode_next;
        end
        `CSC_RUN_CTRL_OFFSET: begin
          run_ctrl_reg <= pwdata[7:0] & `CSC_RUN_CTRL_MASK;
        end
        `CSC_SUPPLY_OFFSET: begin
          supply_reg <= pwdata[7:0] & `CSC_SUPPLY_MASK;
        end
        `CSC_SYS_SELECT_OFFSET: begin
          sys_select_reg <= pwdata[7:0] & `CSC_SYS_SELECT_MASK;
        end
        default: begin
          sys_select_reg <= sys_select_reg;
        end
      endcase
    end
  end

  // A switch completes only once the target source reports stable; software is
  // not stalled meanwhile and must poll the status bits, which lead cpu_clock_from_sub and main_clock_from_ext by one cycle.
  assign main_source_stable = main_status_reg ? main_stable_s : fast_stable_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_status_reg <= 1'b0;
      main_status_reg <= 1'b0;
    end else begin
      if (sys_select_reg[`CSC_MAIN_CLOCK_SOURCE_SELECT_BIT] != main_status_reg) begin
        if (sys_select_reg[`CSC_MAIN_CLOCK_SOURCE_SELECT_BIT] ? main_stable_s : fast_stable_s) begin
          main_status_reg <= sys_select_reg[`CSC_MAIN_CLOCK_SOURCE_SELECT_BIT];
        end
      end
      if (sys_select_reg[`CSC_CPU_CLOCK_SELECT_BIT] != cpu_status_reg) begin
        if (sys_select_reg[`CSC_CPU_CLOCK_SELECT_BIT] ? sub_stable_s : main_source_stable) begin
          cpu_status_reg <= sys_select_reg[`CSC_CPU_CLOCK_SELECT_BIT];
        end
      end
    end
  end

  assign sub_running = ((sub_mode == `CSC_PIN_MODE_OSC) || (sub_mode == `CSC_PIN_MODE_EXT)) &&
                       !run_ctrl_reg[`CSC_SUB_OSC_HALT_BIT];
  assign low_power = stop_mode || (halt_mode && cpu_status_reg);

  // Registered pin and clock controls.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_pin_port_mode <= 1'b1;
      main_osc_run <= 1'b0;
      main_ext_clock_valid <= 1'b0;
      main_freq_range <= 1'b0;
      sub_pin_port_mode <= 1'b1;
      sub_osc_run <= 1'b0;
      sub_ext_clock_valid <= 1'b0;
      sub_drive_mode <= 2'h0;
      fast_osc_run <= 1'b1;
      sub_clock_periph_en <= 1'b0;
      sub_clock_rtc_timer_en <= 1'b0;
      interval_timer_clock_sel <= 1'b0;
      cpu_clock_from_sub <= 1'b0;
      main_clock_from_ext <= 1'b0;
    end else begin
      main_pin_port_mode <= (main_mode != `CSC_PIN_MODE_OSC) && (main_mode != `CSC_PIN_MODE_EXT);
      main_osc_run <= (main_mode == `CSC_PIN_MODE_OSC) && !run_ctrl_reg[`CSC_MAIN_OSC_HALT_BIT];
      main_ext_clock_valid <= (main_mode == `CSC_PIN_MODE_EXT) && !run_ctrl_reg[`CSC_MAIN_OSC_HALT_BIT];
      main_freq_range <= pin_mode_reg[`CSC_MAIN_FREQ_RANGE_BIT];
      sub_pin_port_mode <= (sub_mode != `CSC_PIN_MODE_OSC) && (sub_mode != `CSC_PIN_MODE_EXT);
      sub_osc_run <= (sub_mode == `CSC_PIN_MODE_OSC) && !run_ctrl_reg[`CSC_SUB_OSC_HALT_BIT];
      sub_ext_clock_valid <= (sub_mode == `CSC_PIN_MODE_EXT) && !run_ctrl_reg[`CSC_SUB_OSC_HALT_BIT];
      sub_drive_mode <= pin_mode_reg[`CSC_SUB_DRIVE_MODE_HI_BIT:`CSC_SUB_DRIVE_MODE_LO_BIT];
      fast_osc_run <= !run_ctrl_reg[`CSC_FAST_OSC_HALT_BIT];
      sub_clock_periph_en <= sub_running && !(low_power && supply_reg[`CSC_SUB_SUPPLY_GATING_BIT]);
      sub_clock_rtc_timer_en <= sub_running;
      interval_timer_clock_sel <= supply_reg[`CSC_INTERVAL_TIMER_CLOCK_SEL_BIT];
      cpu_clock_from_sub <= cpu_status_reg;
      main_clock_from_ext <= main_status_reg;
    end
  end

endmodule

//--- inc/clock_source_control_regs.vh
`ifndef CLOCK_SOURCE_CONTROL_REGS_VH
`define CLOCK_SOURCE_CONTROL_REGS_VH

// Register byte offsets on the APB window.
`define CSC_PIN_MODE_OFFSET 8'h00
`define CSC_RUN_CTRL_OFFSET 8'h04
`define CSC_SUPPLY_OFFSET 8'h08
`define CSC_SYS_SELECT_OFFSET 8'h0c

// Field positions in clock_pin_mode_config.
`define CSC_MAIN_EXT_CLOCK_SEL_BIT 7
`define CSC_MAIN_OSC_PIN_SEL_BIT 6
`define CSC_SUB_EXT_CLOCK_SEL_BIT 5
`define CSC_SUB_OSC_PIN_SEL_BIT 4
`define CSC_SUB_DRIVE_MODE_HI_BIT 2
`define CSC_SUB_DRIVE_MODE_LO_BIT 1
`define CSC_MAIN_FREQ_RANGE_BIT 0

// Field positions in oscillator_run_control.
`define CSC_MAIN_OSC_HALT_BIT 7
`define CSC_SUB_OSC_HALT_BIT 6
`define CSC_FAST_OSC_HALT_BIT 0

// Field positions in subclock_supply_control.
`define CSC_SUB_SUPPLY_GATING_BIT 7
`define CSC_INTERVAL_TIMER_CLOCK_SEL_BIT 4

// Field positions in system_clock_select.
`define CSC_CPU_CLOCK_STATUS_BIT 7
`define CSC_CPU_CLOCK_SELECT_BIT 6
`define CSC_MAIN_CLOCK_STATUS_BIT 5
`define CSC_MAIN_CLOCK_SOURCE_SELECT_BIT 4

// Pin mode codes, {ext_clock_sel, osc_pin_sel}.
`define CSC_PIN_MODE_OSC 2'h1
`define CSC_PIN_MODE_EXT 2'h3
// Drive mode code that software must never write.
`define CSC_DRIVE_MODE_PROHIBITED 2'h3

// Writable bit masks; reserved bits read as zero.
`define CSC_PIN_MODE_MASK 8'hf7
`define CSC_RUN_CTRL_MASK 8'hc1
`define CSC_SUPPLY_MASK 8'h90
`define CSC_SYS_SELECT_MASK 8'h50

// Reset values.
`define CSC_PIN_MODE_RESET 8'h00
`define CSC_RUN_CTRL_RESET 8'hc0
`define CSC_SUPPLY_RESET 8'h00
`define CSC_SYS_SELECT_RESET 8'h00

`endif

//--- verification/clock_source_control_monitor.sv
`timescale 1ns/1ps
module clock_source_control_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire main_clock_stable,
  input wire sub_clock_stable,
  input wire main_pin_port_mode,
  input wire main_osc_run,
  input wire main_ext_clock_valid,
  input wire sub_pin_port_mode,
  input wire sub_osc_run,
  input wire sub_ext_clock_valid,
  input wire [1:0] sub_drive_mode,
  input wire cpu_clock_from_sub,
  input wire main_clock_from_ext
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_main_mode_excl: assert property (main_pin_port_mode + main_osc_run + main_ext_clock_valid <= 2'd1)
    else $error("main pin mode outputs overlap");
  a_sub_mode_excl: assert property (sub_pin_port_mode + sub_osc_run + sub_ext_clock_valid <= 2'd1)
    else $error("sub pin mode outputs overlap");
  a_drive_legal: assert property (sub_drive_mode != 2'h3)
    else $error("forbidden drive mode on output");
  a_main_switch_src: assert property ($rose(main_clock_from_ext) |-> $past(main_clock_stable, 2))
    else $error("main clock switched to unstable source");
  a_sub_switch_src: assert property ($rose(cpu_clock_from_sub) |-> $past(sub_clock_stable, 2))
    else $error("cpu clock switched to unstable subclock");
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not after one wait cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_error_in_access: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access phase");
  cover property ($rose(cpu_clock_from_sub));
  cover property ($rose(main_clock_from_ext));
  cover property (pslverr);
endmodule
bind clock_source_control clock_source_control_monitor i_clock_source_control_monitor (.*);

//--- verification/osc_model.sv
`timescale 1ns/1ps
module osc_model #(parameter int SETTLE = 20) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic main_osc_run,
  input wire logic main_ext_clock_valid,
  input wire logic sub_osc_run,
  input wire logic sub_ext_clock_valid,
  input wire logic fast_osc_run,
  output logic main_clock_stable,
  output logic sub_clock_stable,
  output logic fast_osc_stable
);
  int cnt[3];
  logic [2:0] on;
  assign on = {fast_osc_run, sub_osc_run | sub_ext_clock_valid, main_osc_run | main_ext_clock_valid};
  // A source reports stable only after running SETTLE cycles; any stop restarts the count.
  always @(posedge pclk or negedge presetn) begin
    for (int k = 0; k < 3; k++) begin
      if (!presetn || !on[k]) cnt[k] <= 0;
      else if (cnt[k] < SETTLE) cnt[k] <= cnt[k] + 1;
    end
  end
  assign main_clock_stable = cnt[0] >= SETTLE;
  assign sub_clock_stable = cnt[1] >= SETTLE;
  assign fast_osc_stable = cnt[2] >= SETTLE;
endmodule

//--- verification/test_clock_source_control.sv
`timescale 1ns/1ps
module test_clock_source_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0, halt_mode = 0;
  logic [7:0] paddr = 8'h00, rnd;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, main_pin_port_mode, main_osc_run, main_ext_clock_valid, main_freq_range;
  logic sub_pin_port_mode, sub_osc_run, sub_ext_clock_valid, fast_osc_run, sub_clock_periph_en;
  logic sub_clock_rtc_timer_en, interval_timer_clock_sel, cpu_clock_from_sub, main_clock_from_ext;
  logic main_clock_stable, sub_clock_stable, fast_osc_stable;
  logic [1:0] sub_drive_mode;
  logic [32:0] exp_q[$], e;
  int err_total = 0, num_checks = 0, seed = 84146, n;
  clock_source_control i_clock_source_control (.*);
  osc_model i_osc_model (.*);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic fail(input string m);
    $display("BAD %0t %s", $time, m);
    err_total++;
  endtask
  task automatic chk(input logic [1:0] g, input logic [1:0] w, input string m);
    num_checks++;
    if (g !== w) fail(m);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    if (k == 20) fail("no ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic er);
    exp_q.push_back({er, d});
    xfer(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      num_checks++;
      e = exp_q.pop_front();
      if ({pslverr, prdata} !== e) fail("read data");
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail("timeout");
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(main_pin_port_mode, 1, "port reset");
    chk(fast_osc_run, 1, "fast reset");
    rd(8'h00, 32'h00, 1'b0);
    rd(8'h04, 32'hc0, 1'b0);
    rd(8'h08, 32'h00, 1'b0);
    rd(8'h0c, 32'h00, 1'b0);
    rd(8'h10, 32'h00, 1'b1);
    for (int h = 0; h < 2; h++) begin
      xfer(1'b1, 8'h04, h ? 32'hc0 : 32'h00);
      for (int i = 0; i < 16; i++) begin
        xfer(1'b1, 8'h00, i << 4);
        settle;
        chk(main_pin_port_mode, !i[2], "main port");
        chk(main_osc_run, i[3:2] == 2'h1 && !h, "main osc");
        chk(main_ext_clock_valid, i[3:2] == 2'h3 && !h, "main ext");
        chk(sub_pin_port_mode, !i[0], "sub port");
        chk(sub_osc_run, i[1:0] == 2'h1 && !h, "sub osc");
        chk(sub_ext_clock_valid, i[1:0] == 2'h3 && !h, "sub ext");
      end
    end
    for (int j = 0; j < 8; j++) begin
      rnd = $random(seed);
      if (rnd[2:1] == 2'h3) rnd[2] = 1'b0;
      xfer(1'b1, 8'h00, {24'h0, rnd});
      settle;
      rd(8'h00, {24'h0, rnd & 8'hf7}, 1'b0);
      chk(sub_drive_mode, rnd[2:1], "drive");
      chk(main_freq_range, rnd[0], "freq");
    end
    xfer(1'b1, 8'h00, 32'h02);
    xfer(1'b1, 8'h00, 32'h06);
    rd(8'h00, 32'h02, 1'b0);
    xfer(1'b1, 8'h00, 32'hf0);
    xfer(1'b1, 8'h0c, 32'hf0);
    settle;
    rd(8'h0c, 32'h50, 1'b0);
    xfer(1'b1, 8'h04, 32'h00);
    n = 0;
    while (!(cpu_clock_from_sub === 1'b1 && main_clock_from_ext === 1'b1) && n < 200) begin
      n++;
      @(posedge pclk);
    end
    chk(n >= 20 && n < 200, 1, "switch time");
    rd(8'h0c, 32'hf0, 1'b0);
    halt_mode <= 1'b1;
    xfer(1'b1, 8'h08, 32'h90);
    settle;
    chk(sub_clock_periph_en, 0, "gated");
    chk(sub_clock_rtc_timer_en, 1, "rtc");
    chk(interval_timer_clock_sel, 1, "timer sel");
    halt_mode <= 1'b0;
    stop_mode <= 1'b1;
    settle;
    chk(sub_clock_periph_en, 0, "stop gated");
    stop_mode <= 1'b0;
    settle;
    chk(sub_clock_periph_en, 1, "run ungated");
    halt_mode <= 1'b1;
    xfer(1'b1, 8'h08, 32'h00);
    settle;
    chk(sub_clock_periph_en, 1, "ungated");
    halt_mode <= 1'b0;
    xfer(1'b1, 8'h04, 32'h01);
    settle;
    chk(fast_osc_run, 0, "fast halt");
    rd(8'h04, 32'h01, 1'b0);
    tally_and_finish;
  end
endmodule
